/* design/fpc_flash_ctrl.sv */
// Notes on behaviour
// - Main segments are 512 bytes, information segments 128 bytes.
// - Power-up clear resets every control bit.
// - Bad write key sets key-violation flag and requests power-up clear.
// - First control register reads 096h in its upper byte.
// - Erase bit plus dummy write erases that segment; bit self-clears.
// - Mass-erase bit plus main write erases main segments; bit self-clears.
// - Array write without write-enable is refused with access violation.
// - Only five bit combinations are accepted; others flag access violation.
// - Writing first register during an operation flags access violation.
// - Writing second register while busy flags access violation.
// - Timing clock divided by six-bit field plus one.
// - Clock select: 0 ACLK, 1 MCLK, 2 or 3 SMCLK.
// - Timing generator reset by power-up clear and emergency exit.
// - Busy sets at start, holds in segment wait, clears on completion.
// - Fetch during segment write flags violation; reads never do.
// - Software may set access violation, which also raises the NMI.
// - Wait flag shows segment write ready for more data.
// - Flash fetch during operation returns jump-to-self until it ends.
// - Lock refuses program and erase; any access violation the controller detects sets lock.
// - Emergency exit aborts, clears first register, always reads zero.
module fpc_flash_ctrl (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] busAddr,
  input  wire logic [15:0] busWrData,
  input  wire logic        busWrEn,
  input  wire logic        busRdEn,
  input  wire logic        busFetch,
  output logic      [15:0] busRdData,
  output logic             busRdValid,
  output logic             fetchSubst,
  input  wire logic        aclkPin,
  input  wire logic        mclkPin,
  input  wire logic        smclkPin,
  output logic             arrProgram,
  output logic             arrErase,
  output logic             arrEraseMain,
  output logic             arrEraseInfo,
  output logic      [15:0] arrAddr,
  output logic      [15:0] arrData,
  output logic             clearRequest,
  output logic             nmiRequest,
  output logic             accvFlag
);

  fpc_pkg::fpc_state_t state_reg;
  fpc_pkg::fpc_state_t state_next;
  logic [7:0]  opCtl_reg;
  logic [7:0]  timCtl_reg;
  logic        keyFlag_reg;
  logic        accv_reg;
  logic        lock_reg;
  logic        segMode_reg;
  logic [11:0] tickCnt_reg;
  logic [11:0] target_reg;
  logic        eraseMain_reg;
  logic        eraseInfo_reg;
  logic [15:0] arrAddr_reg;
  logic [15:0] arrData_reg;
  logic [15:0] rdData_reg;
  logic        rdValid_reg;
  logic        subst_reg;
  logic        clear_reg;
  logic        nmi_reg;

  fpc_tgen_if tgBus ();

  fpc_timing_gen u_tgen (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .aclkPin  (aclkPin),
    .mclkPin  (mclkPin),
    .smclkPin (smclkPin),
    .tg       (tgBus)
  );

  // ----------------------------------------------------------------
  // Address and key decode
  // ----------------------------------------------------------------
  wire        inMain    = busAddr >= fpc_pkg::MAIN_LO;
  wire        inInfo    = (busAddr >= fpc_pkg::INFO_LO) && (busAddr <= fpc_pkg::INFO_HI);
  wire        inFlash   = inMain || inInfo;
  wire        keyOk     = busWrData[15:8] == fpc_pkg::KEY_WRITE;
  wire        wrOpAny   = busWrEn && (busAddr == fpc_pkg::OPCTL_ADDR);
  wire        wrTimAny  = busWrEn && (busAddr == fpc_pkg::TIMCTL_ADDR);
  wire        wrStatAny = busWrEn && (busAddr == fpc_pkg::STATCTL_ADDR);
  wire        wrOp      = wrOpAny && keyOk;
  wire        wrTim     = wrTimAny && keyOk;
  wire        wrStat    = wrStatAny && keyOk;
  wire        keyBad    = (wrOpAny || wrTimAny || wrStatAny) && !keyOk;

  wire        busyBit   = state_reg != fpc_pkg::FS_IDLE;
  wire        active    = (state_reg == fpc_pkg::FS_PROG) || (state_reg == fpc_pkg::FS_ERASE);
  wire        idle      = state_reg == fpc_pkg::FS_IDLE;
  wire        waitBit   = state_reg == fpc_pkg::FS_SEGWAIT;
  wire        opDone    = active && tgBus.tick && (tickCnt_reg == target_reg - 12'h001);
  wire        abortReq  = wrStat && busWrData[fpc_pkg::STB_ABORT];

  // ----------------------------------------------------------------
  // Operation start decode
  // ----------------------------------------------------------------
  wire [3:0]  combo     = {opCtl_reg[fpc_pkg::OPB_SEGWR], opCtl_reg[fpc_pkg::OPB_WREN],
                           opCtl_reg[fpc_pkg::OPB_MASS], opCtl_reg[fpc_pkg::OPB_ERASE]};
  wire        flashWr   = busWrEn && inFlash;
  wire        okWr      = flashWr && !lock_reg;
  wire        startProg = okWr && idle && (combo == 4'b0100);
  wire        startSeg  = okWr && (idle || waitBit) && (combo == 4'b1100);
  wire        startSegE = okWr && idle && (combo == 4'b0001);
  wire        startMass = okWr && idle && inMain && (combo == 4'b0010);
  wire        startFull = okWr && idle && (combo == 4'b0011);
  wire        startEr   = startSegE || startMass || startFull;
  wire        startAny  = startProg || startSeg || startEr;

  // ----------------------------------------------------------------
  // Access violation sources
  // ----------------------------------------------------------------
  // Refused array write.
  wire        flashViol = flashWr && !startAny;
  wire        opViol    = wrOp && active;
  wire        timViol   = wrTim && busyBit;
  wire        fetchViol = busFetch && segMode_reg && busyBit;
  wire        accvSet   = flashViol || opViol || timViol || fetchViol;
  wire        swAccvSet = wrStat && busWrData[fpc_pkg::STB_ACCV] && !accv_reg;
  wire        fetchHold = busFetch && inFlash && busyBit;
  wire [15:0] segBase   = busAddr & (inMain ? fpc_pkg::MAIN_SEG_MASK : fpc_pkg::INFO_SEG_MASK);

  wire [7:0]  statLow   = {3'b000, lock_reg, waitBit, accv_reg, keyFlag_reg, busyBit};
  wire [15:0] rdMux     = (busAddr == fpc_pkg::OPCTL_ADDR)   ? {fpc_pkg::KEY_READ, opCtl_reg}  :
                          (busAddr == fpc_pkg::TIMCTL_ADDR)  ? {fpc_pkg::KEY_READ, timCtl_reg} :
                          (busAddr == fpc_pkg::STATCTL_ADDR) ? {fpc_pkg::KEY_READ, statLow}    : 16'h0000;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      fpc_pkg::FS_IDLE: begin
        if (startProg || startSeg) begin
          state_next = fpc_pkg::FS_PROG;
        end else if (startEr) begin
          state_next = fpc_pkg::FS_ERASE;
        end
      end
      fpc_pkg::FS_PROG: begin
        if (opDone) begin
          state_next = segMode_reg ? fpc_pkg::FS_SEGWAIT : fpc_pkg::FS_IDLE;
        end
      end
      fpc_pkg::FS_ERASE: begin
        if (opDone) begin
          state_next = fpc_pkg::FS_IDLE;
        end
      end
      fpc_pkg::FS_SEGWAIT: begin
        if (startSeg) begin
          state_next = fpc_pkg::FS_PROG;
        end else if (!opCtl_reg[fpc_pkg::OPB_SEGWR]) begin
          state_next = fpc_pkg::FS_IDLE;
        end
      end
    endcase
    if (abortReq) begin
      state_next = fpc_pkg::FS_IDLE;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg   <= fpc_pkg::FS_IDLE;
      segMode_reg <= 1'b0;
      tickCnt_reg <= 12'h000;
      target_reg  <= fpc_pkg::PROG_TICKS;
    end else begin
      state_reg <= state_next;
      if (startAny) begin
        segMode_reg <= startSeg;
        tickCnt_reg <= 12'h000;
        target_reg  <= startSeg ? fpc_pkg::SEGPR_TICKS :
                       startProg ? fpc_pkg::PROG_TICKS :
                       startSegE ? fpc_pkg::ERASE_TICKS : fpc_pkg::MASS_TICKS;
      end else if (active && tgBus.tick) begin
        tickCnt_reg <= tickCnt_reg + 12'h001;
      end
      if (state_next == fpc_pkg::FS_IDLE) begin
        segMode_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      opCtl_reg  <= fpc_pkg::OPCTL_RST;
      timCtl_reg <= fpc_pkg::TIMCTL_RST;
    end else begin
      if (abortReq) begin
        opCtl_reg <= fpc_pkg::OPCTL_RST;
      end else if (wrOp && !active) begin
        opCtl_reg <= busWrData[7:0] & fpc_pkg::OPCTL_MASK;
      end else if (opDone && (state_reg == fpc_pkg::FS_ERASE)) begin
        opCtl_reg[fpc_pkg::OPB_ERASE] <= 1'b0;
        opCtl_reg[fpc_pkg::OPB_MASS]  <= 1'b0;
      end
      if (wrTim && !busyBit) begin
        timCtl_reg <= busWrData[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      keyFlag_reg <= 1'b0;
      accv_reg <= 1'b0;
      lock_reg <= 1'b0;
    end else begin
      keyFlag_reg <= keyBad || (wrStat ? busWrData[fpc_pkg::STB_KEYF] : keyFlag_reg);
      accv_reg <= accvSet || (wrStat ? busWrData[fpc_pkg::STB_ACCV] : accv_reg);
      lock_reg <= accvSet || (wrStat ? busWrData[fpc_pkg::STB_LOCK] : lock_reg);
    end
  end

  // ----------------------------------------------------------------
  // Array command, read data and requests
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      eraseMain_reg <= 1'b0;
      eraseInfo_reg <= 1'b0;
      arrAddr_reg   <= 16'h0000;
      arrData_reg   <= 16'h0000;
      rdData_reg    <= 16'h0000;
      rdValid_reg   <= 1'b0;
      subst_reg     <= 1'b0;
      clear_reg     <= 1'b0;
      nmi_reg       <= 1'b0;
    end else begin
      if (startAny) begin
        eraseMain_reg <= startMass || startFull;
        eraseInfo_reg <= startFull;
        arrAddr_reg   <= startSegE ? segBase : busAddr;
        arrData_reg   <= busWrData;
      end else if (abortReq) begin
        eraseMain_reg <= 1'b0;
        eraseInfo_reg <= 1'b0;
      end
      rdValid_reg <= busRdEn || busFetch;
      subst_reg   <= fetchHold;
      if (fetchHold) begin
        rdData_reg <= fpc_pkg::JMP_SELF;
      end else if (busRdEn) begin
        rdData_reg <= rdMux;
      end
      clear_reg <= keyBad;
      nmi_reg <= swAccvSet;
    end
  end

  assign tgBus.srcSel  = timCtl_reg[fpc_pkg::TIM_SEL_LSB +: 2];
  assign tgBus.divider = timCtl_reg[fpc_pkg::TIM_DIV_LSB +: 6];
  // Emergency exit resets the timing generator.
  assign tgBus.tgReset = abortReq;

  assign busRdData    = rdData_reg;
  assign busRdValid   = rdValid_reg;
  assign fetchSubst   = subst_reg;
  assign arrProgram   = state_reg == fpc_pkg::FS_PROG;
  assign arrErase     = state_reg == fpc_pkg::FS_ERASE;
  assign arrEraseMain = eraseMain_reg;
  assign arrEraseInfo = eraseInfo_reg;
  assign arrAddr      = arrAddr_reg;
  assign arrData      = arrData_reg;
  assign clearRequest = clear_reg;
  assign nmiRequest   = nmi_reg;
  assign accvFlag     = accv_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_seg_done;
    (state_reg == fpc_pkg::FS_PROG) && segMode_reg && opDone && !abortReq;
  endsequence

  sequence s_erase_done;
    (state_reg == fpc_pkg::FS_ERASE) && opDone && !abortReq;
  endsequence

  a_key_reset: assert property (keyBad |=> clearRequest && keyFlag_reg ##1 clearRequest == $past(keyBad))
    else $error("bad key did not raise one reset request");
  a_read_key: assert property (busRdEn && !fetchHold && busAddr == fpc_pkg::OPCTL_ADDR
                               |=> busRdData[15:8] == fpc_pkg::KEY_READ)
    else $error("first register upper byte wrong");
  a_erase_clear: assert property (s_erase_done |=> idle && !opCtl_reg[1] && !opCtl_reg[2])
    else $error("erase bits not cleared at end");
  a_write_refuse: assert property (flashWr && idle && combo == 4'b0000
                                 |=> accv_reg && lock_reg && idle)
    else $error("write without enable not refused");
  a_op_busy: assert property (opViol && !abortReq && !opDone |=> accv_reg && $stable(opCtl_reg))
    else $error("first register changed during operation");
  a_tim_busy: assert property (timViol |=> accv_reg && $stable(timCtl_reg))
    else $error("second register changed while busy");
  a_seg_wait: assert property (s_seg_done |=> waitBit && busyBit)
    else $error("segment wait not entered");
  a_fetch_subst: assert property (fetchHold |=> fetchSubst && busRdData == fpc_pkg::JMP_SELF)
    else $error("flash fetch not substituted while busy");
  a_sw_nmi: assert property (swAccvSet |=> nmiRequest && accv_reg)
    else $error("software set did not raise nmi");
  a_exit_abort: assert property (abortReq |=> idle && opCtl_reg == fpc_pkg::OPCTL_RST)
    else $error("emergency exit did not abort");
  a_busy_start: assert property (startAny && !abortReq |=> busyBit && !waitBit)
    else $error("busy not set at start");

endmodule

/* include/fpc_pkg.sv */
package fpc_pkg;

  // ----------------------------------------------------------------
  // Register addresses and keys
  // ----------------------------------------------------------------
  localparam logic [15:0] OPCTL_ADDR   = 16'h0128;
  localparam logic [15:0] TIMCTL_ADDR  = 16'h012a;
  localparam logic [15:0] STATCTL_ADDR = 16'h012c;
  localparam logic [7:0]  KEY_WRITE    = 8'ha5;
  localparam logic [7:0]  KEY_READ     = 8'h96;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OPB_ERASE = 1;
  localparam int OPB_MASS  = 2;
  localparam int OPB_WREN  = 6;
  localparam int OPB_SEGWR = 7;
  localparam int STB_BUSY  = 0;
  localparam int STB_KEYF  = 1;
  localparam int STB_ACCV  = 2;
  localparam int STB_WAIT  = 3;
  localparam int STB_LOCK  = 4;
  localparam int STB_ABORT = 5;
  localparam int TIM_DIV_LSB = 0;
  localparam int TIM_SEL_LSB = 6;

  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [7:0] OPCTL_RST  = 8'h00;
  localparam logic [7:0] TIMCTL_RST = 8'h00;
  localparam logic [7:0] OPCTL_MASK = 8'hc6;

  // ----------------------------------------------------------------
  // Flash map and segment sizes
  // ----------------------------------------------------------------
  localparam logic [15:0] MAIN_LO       = 16'hf000;
  localparam logic [15:0] INFO_LO       = 16'h1000;
  localparam logic [15:0] INFO_HI       = 16'h10ff;
  localparam logic [15:0] MAIN_SEG_MASK = 16'hfe00;
  localparam logic [15:0] INFO_SEG_MASK = 16'hff80;
  localparam logic [15:0] JMP_SELF      = 16'h3fff;

  // ----------------------------------------------------------------
  // Operation lengths in timing ticks
  // ----------------------------------------------------------------
  localparam logic [11:0] PROG_TICKS  = 12'h020;
  localparam logic [11:0] SEGPR_TICKS = 12'h014;
  localparam logic [11:0] ERASE_TICKS = 12'hfa0;
  localparam logic [11:0] MASS_TICKS  = 12'hfa0;

  localparam logic [1:0] SRC_ACLK = 2'h0;
  localparam logic [1:0] SRC_MCLK = 2'h1;

  typedef enum logic [1:0] {
    FS_IDLE    = 2'b00,
    FS_PROG    = 2'b01,
    FS_ERASE   = 2'b10,
    FS_SEGWAIT = 2'b11
  } fpc_state_t;

endpackage

/* include/fpc_tgen_if.sv */
interface fpc_tgen_if;
  logic [1:0] srcSel;
  logic [5:0] divider;
  logic       tgReset;
  logic       tick;
  modport ctrl (output srcSel, output divider, output tgReset, input tick);
  modport gen  (input srcSel, input divider, input tgReset, output tick);
endinterface

/* design/fpc_timing_gen.sv */
module fpc_timing_gen (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic aclkPin,
  input  wire logic mclkPin,
  input  wire logic smclkPin,
  fpc_tgen_if.gen   tg
);

  logic [2:0] pinIn;
  logic [2:0] syncA_reg;
  logic [2:0] syncB_reg;
  logic [2:0] prev_reg;
  logic [2:0] srcEdge;
  logic [5:0] divCnt_reg;
  logic       tick_reg;
  logic       selEdge;

  assign pinIn = {smclkPin, mclkPin, aclkPin};

  // ----------------------------------------------------------------
  // Source synchronisers and edge detect
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_src
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          syncA_reg[i] <= 1'b0;
          syncB_reg[i] <= 1'b0;
          prev_reg[i]  <= 1'b0;
        end else begin
          syncA_reg[i] <= pinIn[i];
          syncB_reg[i] <= syncA_reg[i];
          prev_reg[i]  <= syncB_reg[i];
        end
      end
      assign srcEdge[i] = syncB_reg[i] & ~prev_reg[i];
    end
  endgenerate

  assign selEdge = (tg.srcSel == fpc_pkg::SRC_ACLK) ? srcEdge[0] :
                   (tg.srcSel == fpc_pkg::SRC_MCLK) ? srcEdge[1] : srcEdge[2];

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Divide by field plus one.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      divCnt_reg <= 6'h00;
      tick_reg   <= 1'b0;
    end else if (tg.tgReset) begin
      divCnt_reg <= 6'h00;
      tick_reg   <= 1'b0;
    end else begin
      tick_reg <= selEdge && (divCnt_reg == tg.divider);
      if (selEdge) begin
        divCnt_reg <= (divCnt_reg == tg.divider) ? 6'h00 : divCnt_reg + 6'h01;
      end
    end
  end

  assign tg.tick = tick_reg;

  a_tick_spacing: assert property (@(posedge core_clk) disable iff (sys_rst) tick_reg |=> !tick_reg)
    else $error("timing tick on two adjacent cycles");

endmodule

/* tb/fpc_cpu_model.sv */
module fpc_cpu_model (
  input  wire logic        core_clk,
  input  wire logic [15:0] busRdData,
  input  wire logic        busRdValid,
  input  wire logic        fetchSubst,
  output logic      [15:0] busAddr,
  output logic      [15:0] busWrData,
  output logic             busWrEn,
  output logic             busRdEn,
  output logic             busFetch
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    busAddr = 16'h0000;
    busWrData = 16'h0000;
    busWrEn = 1'b0;
    busRdEn = 1'b0;
    busFetch = 1'b0;
  end

  // A released bus shows the inverse of its last value.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    busAddr <= a;
    busWrData <= d;
    busWrEn <= 1'b1;
    @(posedge core_clk);
    busWrEn <= 1'b0;
    busAddr <= ~a;
    busWrData <= ~d;
    #1;
  endtask

  task automatic rd(input logic [15:0] a, input logic f, output logic [15:0] d, output logic s);
    @(posedge core_clk);
    busAddr <= a;
    busRdEn <= ~f;
    busFetch <= f;
    @(posedge core_clk);
    busRdEn <= 1'b0;
    busFetch <= 1'b0;
    busAddr <= ~a;
    #1;
    d = busRdValid ? busRdData : 16'hdead;
    s = fetchSubst;
  endtask
endmodule

/* tb/test_flash_program_erase_controller.sv */
module test_flash_program_erase_controller;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] BAD [5] = '{8'h00, 8'h42, 8'h44, 8'hc2, 8'h80};
  localparam logic [7:0] OPS [3] = '{8'h02, 8'h04, 8'h06};
  localparam logic [15:0] ADR [3] = '{16'h10a7, 16'hf100, 16'h1000};
  localparam logic [15:0] EXP [3] = '{16'h0004, 16'h0006, 16'h0007};
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] busAddr, busWrData, busRdData, arrAddr, arrData;
  logic        busWrEn, busRdEn, busFetch, busRdValid, fetchSubst, arrProgram, arrErase;
  logic        arrEraseMain, arrEraseInfo, clearRequest, nmiRequest, accvFlag;
  logic        pinTog = 1'b0;
  logic [2:0]  pinEn = 3'h7;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;
  wire logic [15:0] arrFlags = {9'h000, clearRequest, nmiRequest, accvFlag, arrProgram, arrErase, arrEraseMain,
                                arrEraseInfo};

  fpc_flash_ctrl dut (.core_clk(core_clk), .sys_rst(sys_rst), .busAddr(busAddr), .busWrData(busWrData),
    .busWrEn(busWrEn), .busRdEn(busRdEn), .busFetch(busFetch), .busRdData(busRdData), .busRdValid(busRdValid),
    .fetchSubst(fetchSubst), .aclkPin(pinTog & pinEn[0]), .mclkPin(pinTog & pinEn[1]),
    .smclkPin(pinTog & pinEn[2]), .arrProgram(arrProgram), .arrErase(arrErase), .arrEraseMain(arrEraseMain),
    .arrEraseInfo(arrEraseInfo), .arrAddr(arrAddr), .arrData(arrData), .clearRequest(clearRequest),
    .nmiRequest(nmiRequest), .accvFlag(accvFlag));

  fpc_cpu_model cpu (.core_clk(core_clk), .busRdData(busRdData), .busRdValid(busRdValid),
    .fetchSubst(fetchSubst), .busAddr(busAddr), .busWrData(busWrData), .busWrEn(busWrEn),
    .busRdEn(busRdEn), .busFetch(busFetch));

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    pinTog <= ~pinTog;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  task automatic results;
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rr(input logic [15:0] a, input logic [7:0] e);
    logic [15:0] d;
    logic        s;
    cpu.rd(a, 1'b0, d, s);
    chk(d, {fpc_pkg::KEY_READ, e});
  endtask

  task automatic rOp(input logic [7:0] e);
    rr(fpc_pkg::OPCTL_ADDR, e);
  endtask

  task automatic rSt(input logic [7:0] e);
    rr(fpc_pkg::STATCTL_ADDR, e);
  endtask

  task automatic wOp(input logic [7:0] v);
    cpu.wr(fpc_pkg::OPCTL_ADDR, {fpc_pkg::KEY_WRITE, v});
  endtask

  task automatic wTm(input logic [7:0] v);
    cpu.wr(fpc_pkg::TIMCTL_ADDR, {fpc_pkg::KEY_WRITE, v});
  endtask

  task automatic wSt(input logic [7:0] v);
    cpu.wr(fpc_pkg::STATCTL_ADDR, {fpc_pkg::KEY_WRITE, v});
  endtask

  task automatic wi(output int c);
    c = 0;
    while ((arrProgram | arrErase) !== 1'b0 && c < 9000) begin
      @(posedge core_clk);
      #1;
      c++;
    end
  endtask

  task automatic tReset;
    logic [15:0] d;
    logic        s;
    rOp(8'h00);
    rr(fpc_pkg::TIMCTL_ADDR, 8'h00);
    cpu.rd(16'h0130, 1'b0, d, s);
    chk(d, 16'h0000);
    rSt(8'h00);
  endtask

  task automatic tKey;
    cpu.wr(fpc_pkg::OPCTL_ADDR, 16'h5a42);
    chk(arrFlags, 16'h0040);
    rOp(8'h00);
    rSt(8'h02);
    wSt(8'h00);
  endtask

  task automatic tBusy;
    logic [15:0] d;
    logic        s;
    int          c;
    wOp(8'h40);
    cpu.wr(16'hf020, 16'haaaa);
    chk(arrFlags, 16'h0008);
    chk(arrAddr, 16'hf020);
    chk(arrData, 16'haaaa);
    cpu.rd(16'hf000, 1'b1, d, s);
    chk(d, fpc_pkg::JMP_SELF);
    chk(16'(s), 16'h0001);
    rSt(8'h01);
    wOp(8'h40);
    rSt(8'h15);
    wSt(8'h00);
    wTm(8'h05);
    rSt(8'h15);
    rr(fpc_pkg::TIMCTL_ADDR, 8'h00);
    wi(c);
    rSt(8'h14);
    wSt(8'h00);
  endtask

  task automatic tViol;
    foreach (BAD[i]) begin
      wOp(BAD[i]);
      cpu.wr(16'hf000, 16'h0000);
      chk(arrFlags, 16'h0010);
      rSt(8'h14);
      wSt(8'h00);
    end
    wSt(8'h10);
    wOp(8'h40);
    cpu.wr(16'hf000, 16'h0000);
    chk(arrFlags, 16'h0010);
    wSt(8'h00);
    wOp(8'h04);
    cpu.wr(16'h1000, 16'h0000);
    chk(arrFlags, 16'h0010);
    wSt(8'h00);
  endtask

  task automatic tErase;
    int c;
    wOp(8'h02);
    cpu.wr(16'hf234, 16'h0000);
    chk(arrFlags, 16'h0004);
    chk(arrAddr, 16'hf200);
    wi(c);
    rOp(8'h00);
    for (int i = 0; i < 3; i++) begin
      wOp(OPS[i]);
      cpu.wr(ADR[i], 16'h0000);
      chk(arrFlags, EXP[i]);
      if (i == 0) chk(arrAddr, 16'h1080);
      wSt(8'h20);
      chk(arrFlags, 16'h0000);
      rOp(8'h00);
      rSt(8'h00);
    end
  endtask

  task automatic tSeg;
    logic [15:0] d;
    logic        s;
    int          c;
    wOp(8'hc0);
    cpu.wr(16'hf000, 16'h1111);
    rSt(8'h01);
    wi(c);
    rSt(8'h09);
    // Next word stays in the segment.
    cpu.wr(16'hf002, 16'h2222);
    chk(arrFlags, 16'h0008);
    wi(c);
    cpu.rd(16'h0200, 1'b1, d, s);
    rSt(8'h1d);
    wOp(8'h00);
    wSt(8'h00);
    cpu.rd(fpc_pkg::STATCTL_ADDR, 1'b0, d, s);
    chk(d & 16'hfff7, 16'h9600);
  endtask

  task automatic tNmi;
    wSt(8'h04);
    chk(arrFlags, 16'h0030);
    wSt(8'h00);
    chk(arrFlags, 16'h0000);
  endtask

  task automatic tTiming(input logic [1:0] sel);
    int c;
    wTm({sel, 6'h01});
    @(posedge core_clk);
    pinEn <= sel[1] ? 3'h4 : (sel[0] ? 3'h2 : 3'h1);
    wOp(8'h40);
    cpu.wr(16'hf040, 16'h5555);
    wi(c);
    chk(16'((c >= 120) && (c <= 136)), 16'h0001);
    rSt(8'h00);
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    tReset();
    tKey();
    tBusy();
    tViol();
    tErase();
    tSeg();
    tNmi();
    for (int i = 0; i < 4; i++) tTiming(2'(i));
    results();
  end
endmodule
